// ---- verilog/alarm_summary_map.vh ----
/*
 Register offsets, field positions, reset values and counts for the alarm summary and
 add clock loss block.
 Assumes a byte-wide register port addressed by the printed offsets.
*/
`ifndef ALARM_SUMMARY_MAP_VH
`define ALARM_SUMMARY_MAP_VH

`define ADDR_W                8
`define DATA_W                8

`define OFS_IRQ_CONTROL       8'h05
`define OFS_ADD_LOSS_MASK     8'h3d
`define OFS_GLOBAL_SUMMARY    8'h50
`define OFS_ADD_LOSS_STATUS   8'h51
`define OFS_ADD_LOSS_LATCHED  8'h52
`define OFS_ADD_LOSS_CONFIG   8'h60

`define BIT_DROP_A_BUS        5
`define BIT_DROP_B_BUS        4
`define BIT_ADD_BUS           3
`define BIT_DROP_A_CHANNEL    2
`define BIT_DROP_B_CHANNEL    1
`define BIT_ADD_CHANNEL       0
`define BIT_MASTER_IRQ_ENABLE 7
`define SUMMARY_W             6

`define BIT_ADD_A             0
`define BIT_ADD_B             1
`define SIDES                 2
`define SIDE_DATA_W           8

`define BIT_ADD_TIMING        0
`define EDGE_SEL_LSB          1
`define EDGE_SEL_W            2
`define EDGE_RISE             2'h0
`define EDGE_FALL             2'h1

`define RST_IRQ_CONTROL       8'h00
`define RST_ADD_LOSS_MASK     2'h0
`define RST_ADD_LOSS_CONFIG   3'h0

`define LOC_CNT_W             6
`define LOC_STUCK_CYCLES      6'h38

`endif

// ---- verilog/alarm_summary_add_clock_loss.v ----
/*
 Global alarm summary register, interrupt output and add bus loss of clock detector.
 Assumes lower-level alarm logic delivers masked latched alarm levels, and that the add
 clocks and register strobes are synchronous to ref_clk, the drop bus clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "alarm_summary_map.vh"

module alarm_summary_add_clock_loss (
	// Register port.
	input  wire                                   ref_clk,
	input  wire                                   sys_rst,
	input  wire [`ADDR_W-1:0]                     reg_addr,
	input  wire [`DATA_W-1:0]                     reg_wdata,
	input  wire                                   reg_wr,
	input  wire                                   reg_rd,
	output reg  [`DATA_W-1:0]                     reg_rdata,

	// Summary sources, each already qualified by the lower mask levels.
	input  wire                                   drop_a_bus_alarm,
	input  wire                                   drop_b_bus_alarm,
	input  wire                                   add_bus_alarm,
	input  wire [7:0]                             drop_a_channel_alarm,
	input  wire [7:0]                             drop_b_channel_alarm,
	input  wire [7:0]                             add_channel_alarm,

	// Add bus line side, one lane per side.
	input  wire [`SIDES-1:0]                      add_clock,
	input  wire [`SIDES*`SIDE_DATA_W-1:0]         add_data_in,
	input  wire [`SIDES-1:0]                      add_parity_in,
	input  wire [`SIDES-1:0]                      add_indicator_in,
	output reg  [`SIDES*`SIDE_DATA_W-1:0]         add_data,
	output reg  [`SIDES-1:0]                      add_parity,
	output reg  [`SIDES-1:0]                      add_data_oe,
	output reg  [`SIDES-1:0]                      add_indicator,
	output reg                                    irq
);

	reg  [`DATA_W-1:0]              irq_control;
	reg  [`SIDES-1:0]               add_loss_mask;
	reg  [2:0]                      add_loss_config;
	reg  [`SUMMARY_W-1:0]           summary;
	reg  [`SUMMARY_W-1:0]           next_summary;
	reg  [`SIDES-1:0]               clock_loss;
	reg  [`SIDES-1:0]               clock_loss_latched;
	reg  [`SIDES-1:0]               add_clock_prev;
	reg  [`LOC_CNT_W*`SIDES-1:0]    stuck_count;
	wire [`SIDES-1:0]               next_clock_loss;
	wire [`SIDES-1:0]               next_clock_loss_latched;
	wire [`LOC_CNT_W*`SIDES-1:0]    next_stuck_count;
	wire                            add_timing;
	wire [`EDGE_SEL_W-1:0]          edge_sel;
	wire                            latched_read;
	wire                            control_write;
	wire                            loss_mask_write;
	wire                            config_write;
	wire [`SUMMARY_W-1:0]           summary_mask;
	wire                            master_irq_enable;

	// Decode and next-state values.
	wire                            hit_control;
	wire                            hit_loss_mask;
	wire                            hit_config;
	wire                            hit_latched;
	reg  [`DATA_W-1:0]              next_irq_control;
	reg  [`SIDES-1:0]               next_add_loss_mask;
	reg  [2:0]                      next_add_loss_config;
	wire [`SIDES-1:0]               loss_to_summary;
	wire                            add_loss_any;
	wire                            drop_a_channel_any;
	wire                            drop_b_channel_any;
	wire                            add_channel_any;
	wire [`SUMMARY_W-1:0]           masked_summary;
	reg                             next_irq;
	reg  [`DATA_W-1:0]              next_rdata;
	wire [`DATA_W-1:0]              mask_word;
	wire [`DATA_W-1:0]              config_word;
	wire [`DATA_W-1:0]              summary_word;
	wire [`DATA_W-1:0]              status_word;
	wire [`DATA_W-1:0]              latched_word;

	assign hit_control       = (reg_addr == `OFS_IRQ_CONTROL);
	assign hit_loss_mask     = (reg_addr == `OFS_ADD_LOSS_MASK);
	assign hit_config        = (reg_addr == `OFS_ADD_LOSS_CONFIG);
	assign hit_latched       = (reg_addr == `OFS_ADD_LOSS_LATCHED);

	assign add_timing        = add_loss_config[`BIT_ADD_TIMING];
	assign edge_sel          = add_loss_config[`EDGE_SEL_LSB +: `EDGE_SEL_W];
	assign latched_read      = reg_rd && hit_latched;
	assign control_write     = reg_wr && hit_control;
	assign loss_mask_write   = reg_wr && hit_loss_mask;
	assign config_write      = reg_wr && hit_config;
	assign summary_mask      = irq_control[`SUMMARY_W-1:0];
	assign master_irq_enable = irq_control[`BIT_MASTER_IRQ_ENABLE];

	// Loss alarms reach the add bus summary only through their own enable bits.
	assign loss_to_summary    = clock_loss_latched & add_loss_mask;
	assign add_loss_any       = |loss_to_summary;
	assign drop_a_channel_any = |drop_a_channel_alarm;
	assign drop_b_channel_any = |drop_b_channel_alarm;
	assign add_channel_any    = |add_channel_alarm;
	assign masked_summary     = summary & summary_mask;

	// Status words are widened here so the unused upper bits always read zero.
	assign mask_word    = {{(`DATA_W-`SIDES){1'b0}}, add_loss_mask};
	assign config_word  = {{(`DATA_W-3){1'b0}}, add_loss_config};
	assign summary_word = {{(`DATA_W-`SUMMARY_W){1'b0}}, summary};
	assign status_word  = {{(`DATA_W-`SIDES){1'b0}}, clock_loss};
	assign latched_word = {{(`DATA_W-`SIDES){1'b0}}, clock_loss_latched};

	// Write decode. Only the three writable offsets are decoded, so writes aimed at
	// the status offsets or at unmapped ones leave every register as it was.
	always @* begin
		next_irq_control     = irq_control;
		next_add_loss_mask   = add_loss_mask;
		next_add_loss_config = add_loss_config;
		if (control_write) begin
			next_irq_control = reg_wdata;
		end
		if (loss_mask_write) begin
			next_add_loss_mask = reg_wdata[`SIDES-1:0];
		end
		if (config_write) begin
			next_add_loss_config = reg_wdata[`EDGE_SEL_LSB+`EDGE_SEL_W-1:0];
		end
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_control     <= `RST_IRQ_CONTROL;
			add_loss_mask   <= `RST_ADD_LOSS_MASK;
			add_loss_config <= `RST_ADD_LOSS_CONFIG;
		end else begin
			irq_control     <= next_irq_control;
			add_loss_mask   <= next_add_loss_mask;
			add_loss_config <= next_add_loss_config;
		end
	end

	// The summary bits are levels, not sticky flags: they drop as soon as the
	// feeding latched alarms are read clear or a mask in their chain is lowered.
	always @* begin
		next_summary = {`SUMMARY_W{1'b0}};
		next_summary[`BIT_DROP_A_BUS]     = drop_a_bus_alarm;
		next_summary[`BIT_DROP_B_BUS]     = drop_b_bus_alarm;
		next_summary[`BIT_ADD_BUS]        = add_bus_alarm | add_loss_any;
		next_summary[`BIT_DROP_A_CHANNEL] = drop_a_channel_any;
		next_summary[`BIT_DROP_B_CHANNEL] = drop_b_channel_any;
		next_summary[`BIT_ADD_CHANNEL]    = add_channel_any;
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			summary <= {`SUMMARY_W{1'b0}};
			irq     <= 1'b0;
		end else begin
			summary <= next_summary;
			irq     <= next_irq;
		end
	end

	// The interrupt is a level: it falls as soon as the summary bit or a mask drops.
	always @* begin
		next_irq = 1'b0;
		if (master_irq_enable) begin
			next_irq = |masked_summary;
		end
	end

	// One detector per add side. The stuck counter saturates at the limit so a dead
	// clock keeps the alarm up without the counter wrapping and ending it falsely.
	genvar side;
	generate
		for (side = 0; side < `SIDES; side = side + 1) begin : loss_side
			wire                  toggled;
			wire [`LOC_CNT_W-1:0] count_now;
			reg  [`LOC_CNT_W-1:0] count_next;
			reg                   loss_next;
			reg                   edge_hit;
			reg                   latch_next;

			// Line side outputs as they will stand after the next edge.
			reg  [`SIDE_DATA_W-1:0] next_out_data;
			reg                   next_out_parity;
			reg                   next_out_oe;
			reg                   next_out_indicator;

			// Edges of the alarm itself, found against the value one edge ago.
			wire                  rise_event;
			wire                  fall_event;
			wire                  stuck_full;

			assign toggled   = add_clock[side] ^ add_clock_prev[side];
			assign count_now = stuck_count[side*`LOC_CNT_W +: `LOC_CNT_W];

			// The full count marks a declared loss; the counter rests there.
			assign stuck_full = (count_now == `LOC_STUCK_CYCLES);
			assign rise_event = loss_next & ~clock_loss[side];
			assign fall_event = ~loss_next & clock_loss[side];

			always @* begin
				count_next = count_now;
				loss_next  = clock_loss[side];
				if (!add_timing) begin
					count_next = {`LOC_CNT_W{1'b0}};
					loss_next  = 1'b0;
				end else if (toggled) begin
					count_next = {`LOC_CNT_W{1'b0}};
					loss_next  = 1'b0;
				end else if (!stuck_full) begin
					count_next = count_now + 6'h01;
					loss_next  = (count_next == `LOC_STUCK_CYCLES);
				end
			end

			always @* begin
				case (edge_sel)
				`EDGE_RISE: begin
					edge_hit = rise_event;
				end
				`EDGE_FALL: begin
					edge_hit = fall_event;
				end
				default: begin
					edge_hit = rise_event | fall_event;
				end
				endcase
				// A new event in the read cycle survives the clear.
				latch_next = edge_hit | (clock_loss_latched[side] & ~latched_read);
			end

			assign next_stuck_count[side*`LOC_CNT_W +: `LOC_CNT_W] = count_next;
			assign next_clock_loss[side]                          = loss_next;
			assign next_clock_loss_latched[side]                  = latch_next;

			// A side in loss stops driving and zeroes its lane, so a floated side
			// never shows a stale byte to anything that still samples it.
			always @* begin
				next_out_data      = add_data_in[side*`SIDE_DATA_W +: `SIDE_DATA_W];
				next_out_parity    = add_parity_in[side];
				next_out_oe        = 1'b1;
				next_out_indicator = add_indicator_in[side];
				if (loss_next) begin
					next_out_data      = {`SIDE_DATA_W{1'b0}};
					next_out_parity    = 1'b0;
					next_out_oe        = 1'b0;
					next_out_indicator = 1'b0;
				end
			end

			always @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					add_data[side*`SIDE_DATA_W +: `SIDE_DATA_W] <= {`SIDE_DATA_W{1'b0}};
					add_parity[side]    <= 1'b0;
					add_data_oe[side]   <= 1'b0;
					add_indicator[side] <= 1'b0;
				end else begin
					add_data[side*`SIDE_DATA_W +: `SIDE_DATA_W] <= next_out_data;
					add_parity[side]    <= next_out_parity;
					add_data_oe[side]   <= next_out_oe;
					add_indicator[side] <= next_out_indicator;
				end
			end
		end
	endgenerate

	// The previous add clock sample is the reference every detector compares with;
	// after reset it reads low, which at worst restarts a count, never raises a loss.
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			add_clock_prev <= {`SIDES{1'b0}};
		end else begin
			add_clock_prev <= add_clock;
		end
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stuck_count <= {(`LOC_CNT_W*`SIDES){1'b0}};
		end else begin
			stuck_count <= next_stuck_count;
		end
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			clock_loss <= {`SIDES{1'b0}};
		end else begin
			clock_loss <= next_clock_loss;
		end
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			clock_loss_latched <= {`SIDES{1'b0}};
		end else begin
			clock_loss_latched <= next_clock_loss_latched;
		end
	end

	// Read data stand for exactly the cycle after the strobe and are zero otherwise,
	// so a bus that ORs several slaves together needs no extra gating.
	always @* begin
		next_rdata = {`DATA_W{1'b0}};
		if (reg_rd) begin
			case (reg_addr)
			`OFS_IRQ_CONTROL: begin
				next_rdata = irq_control;
			end
			`OFS_ADD_LOSS_MASK: begin
				next_rdata = mask_word;
			end
			`OFS_ADD_LOSS_CONFIG: begin
				next_rdata = config_word;
			end
			`OFS_GLOBAL_SUMMARY: begin
				next_rdata = summary_word;
			end
			`OFS_ADD_LOSS_STATUS: begin
				next_rdata = status_word;
			end
			`OFS_ADD_LOSS_LATCHED: begin
				next_rdata = latched_word;
			end
			default: begin
				next_rdata = {`DATA_W{1'b0}};
			end
			endcase
		end
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= {`DATA_W{1'b0}};
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule

`default_nettype wire

// ---- testbench/alarm_summary_checker.sv ----
/*
 Port assertions for the alarm summary and add clock loss block.
 Assumes one clock, ref_clk, and the asynchronous active high sys_rst.
*/
`timescale 1ns/1ps
`default_nettype none
module alarm_summary_checker (
	input wire        ref_clk,
	input wire        sys_rst,
	input wire [7:0]  reg_addr,
	input wire        reg_rd,
	input wire [7:0]  reg_rdata,
	input wire [1:0]  add_clock,
	input wire [15:0] add_data_in,
	input wire [1:0]  add_parity_in,
	input wire [15:0] add_data,
	input wire [1:0]  add_parity,
	input wire [1:0]  add_data_oe,
	input wire [1:0]  add_indicator
);
	logic [7:0] stuck_a;
	logic [1:0] clk_q;
	// The run counter saturates so a long stop cannot wrap into a false match.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stuck_a <= 8'h00;
			clk_q <= 2'h0;
		end else begin
			clk_q <= add_clock;
			stuck_a <= (add_clock[0] != clk_q[0]) ? 8'h00 : stuck_a + {7'h00, stuck_a != 8'hff};
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	chk_float_side_a: assert property (!add_data_oe[0] |-> add_data[7:0] == 8'h00 && !add_parity[0])
		else $error("side a data driven during loss");
	chk_float_side_b: assert property (!add_data_oe[1] |-> add_data[15:8] == 8'h00 && !add_parity[1])
		else $error("side b data driven during loss");
	chk_follow_side_a: assert property (add_data_oe[0] |->
		add_data[7:0] == $past(add_data_in[7:0]) && add_parity[0] == $past(add_parity_in[0]))
		else $error("side a data not passed through");
	chk_follow_side_b: assert property (add_data_oe[1] |->
		add_data[15:8] == $past(add_data_in[15:8]) && add_parity[1] == $past(add_parity_in[1]))
		else $error("side b data not passed through");
	chk_indicator_off: assert property ((add_indicator & ~add_data_oe) == 2'b00)
		else $error("add indicator active during loss");
	chk_stuck_count: assert property ($fell(add_data_oe[0]) |-> stuck_a == 8'd56)
		else $error("loss declared after wrong stuck count");
	chk_recover_a: assert property (!add_data_oe[0] && add_clock[0] != clk_q[0] |-> ##[1:2] add_data_oe[0])
		else $error("side a loss kept after clock edge");
	chk_recover_b: assert property (!add_data_oe[1] && add_clock[1] != clk_q[1] |-> ##[1:2] add_data_oe[1])
		else $error("side b loss kept after clock edge");
	chk_summary_upper: assert property ($past(reg_rd) && $past(reg_addr) == 8'h50 |-> reg_rdata[7:6] == 2'b00)
		else $error("summary upper bits not zero");
	chk_status_read: assert property ($past(reg_rd) && $past(reg_addr) == 8'h51 |-> reg_rdata == {6'h00, ~$past(add_data_oe)})
		else $error("loss status read disagrees with outputs");
endmodule
bind alarm_summary_add_clock_loss alarm_summary_checker u_chk (.ref_clk, .sys_rst, .reg_addr, .reg_rd,
	.reg_rdata, .add_clock, .add_data_in, .add_parity_in, .add_data, .add_parity, .add_data_oe,
	.add_indicator);
`default_nettype wire

// ---- testbench/add_bus_peer.sv ----
/*
 Add bus line side peer: add clocks, data, parity and indicator per side.
 Assumes its clocks are sampled on ref_clk; a stopped clock holds its level.
*/
`timescale 1ns/1ps
`default_nettype none
module add_bus_peer (
	input  wire        ref_clk,
	input  wire [1:0]  stop,
	output var logic [1:0]  add_clock,
	output var logic [15:0] add_data_in,
	output var logic [1:0]  add_parity_in,
	output var logic [1:0]  add_indicator_in
);
	logic half = 1'b0;
	initial begin
		add_clock = 2'h0;
		add_data_in = 16'h0000;
	end
	// Each clock level lasts two samples, well inside the stuck count.
	always @(posedge ref_clk) begin
		half <= ~half;
		add_data_in <= add_data_in + 16'h0101;
		if (half)
			add_clock <= add_clock ^ ~stop;
	end
	assign add_parity_in = {^add_data_in[15:8], ^add_data_in[7:0]};
	assign add_indicator_in = 2'b11;
endmodule
`default_nettype wire

// ---- testbench/tb_alarm_summary_add_clock_loss.sv ----
/*
 Self-checking bench: summary bits, interrupt, add clock loss and its registers.
 Assumes the add bus peer model and a register port sampled on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_alarm_summary_add_clock_loss;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [5:0]  alm = 6'h00;
	logic [1:0]  stop = 2'h0;
	wire  [7:0]  reg_rdata;
	wire  [15:0] add_data_in, add_data;
	wire  [1:0]  add_clock, add_parity_in, add_indicator_in, add_parity, add_data_oe, add_indicator;
	wire         irq;
	int          err_count = 0;
	int          compares = 0;
	int          cycles = 0;
	alarm_summary_add_clock_loss u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.drop_a_bus_alarm(alm[5]), .drop_b_bus_alarm(alm[4]), .add_bus_alarm(alm[3]),
		.drop_a_channel_alarm({alm[2], 7'h00}), .drop_b_channel_alarm({alm[1], 7'h00}),
		.add_channel_alarm({alm[0], 7'h00}), .add_clock(add_clock), .add_data_in(add_data_in),
		.add_parity_in(add_parity_in), .add_indicator_in(add_indicator_in), .add_data(add_data),
		.add_parity(add_parity), .add_data_oe(add_data_oe), .add_indicator(add_indicator), .irq(irq));
	add_bus_peer u_peer (.ref_clk(ref_clk), .stop(stop), .add_clock(add_clock),
		.add_data_in(add_data_in), .add_parity_in(add_parity_in), .add_indicator_in(add_indicator_in));
	initial forever #4 ref_clk = ~ref_clk;
	task automatic complete_run();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// A hung run is cut short well past the expected length of about 500 cycles.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 check($sformatf("reg %h", a), exp, reg_rdata);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(8'h05, 8'h00);
		rd(8'h51, 8'h00);
		wr(8'h50, 8'hff);
		rd(8'h50, 8'h00);
		rd(8'h7f, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(8'h05, 8'h80 | (8'h01 << i));
			alm <= 6'h01 << i;
			idle(3);
			rd(8'h50, 8'h01 << i);
			check("irq", 8'h01, {7'h00, irq});
			wr(8'h05, 8'h01 << i);
			idle(2);
			check("irq", 8'h00, {7'h00, irq});
			wr(8'h05, 8'hbf & ~(8'h01 << i));
			idle(2);
			check("irq", 8'h00, {7'h00, irq});
			@(posedge ref_clk) alm <= 6'h00;
			idle(2);
			rd(8'h50, 8'h00);
		end
		wr(8'h3d, 8'h01);
		// Edge codes 0, 1 and 2 select rising, falling and both.
		for (int e = 0; e < 3; e++) begin
			wr(8'h60, {5'h00, e[1:0], 1'b1});
			stop <= 2'h1;
			idle(60);
			check("oe", 8'h02, {6'h00, add_data_oe});
			check("ind", 8'h02, {6'h00, add_indicator});
			rd(8'h51, 8'h01);
			rd(8'h50, {4'h0, e != 1, 3'h0});
			rd(8'h52, {7'h00, e != 1});
			@(posedge ref_clk) stop <= 2'h0;
			idle(4);
			rd(8'h51, 8'h00);
			rd(8'h52, {7'h00, e != 0});
			rd(8'h52, 8'h00);
		end
		wr(8'h60, 8'h05);
		stop <= 2'h2;
		idle(60);
		rd(8'h50, 8'h00);
		rd(8'h52, 8'h02);
		wr(8'h60, 8'h00);
		stop <= 2'h3;
		idle(70);
		check("oe", 8'h03, {6'h00, add_data_oe});
		rd(8'h51, 8'h00);
		complete_run();
	end
endmodule
`default_nettype wire
